/* verilog/osc_pkg.sv */
/*
 * Constants and carrier types for the output sequencing register bank:
 * register offsets, field positions, reset values and the delay step timing.
 * Assumes a single 125 MHz clock and a register port provided by the
 * surrounding serial interface logic.
 */
// Operation
// RULE1: Output one falls after enable falls by off code times step; zero means none.
// RULE2: Output one rises after enable rises by on code times step.
// RULE3: Output two falls after enable falls by its off code times step.
// RULE4: Output two rises after enable rises by its on code times step.
// RULE5: On-delay range select 1 gives 1 ms steps, else 0.5 ms.
// RULE6: Off-delay range select 1 gives 1 ms steps, else 0.5 ms.
// RULE7: Drive-type bit 0 means push-pull, 1 means open-drain, per output.
// RULE8: Output two gating 1 ANDs its level bit with enable pin.
// RULE9: Sync pin as general output drives output two level bit.
// RULE10: Output one gating 1 ANDs its level bit with enable pin.
// RULE11: Output one follows its level bit.
// RULE12: Pin-function select 0 makes sync pin output two, 1 clock input.
// RULE13: Pull-downs on sync pin and enable pin follow their bits.
// RULE14: Thermal threshold select chooses 125 or 137 degrees.
// RULE15: Spread spectrum follows its enable bit.
// RULE16: PLL bit 0 forces internal oscillator with PLL off.
// RULE17: PLL enabled switches to external clock when present, event on change.
// RULE18: Host writes zero to reserved bit 5 of clock sync control.
// RULE19: Host frequency code is MHz minus one, at most 0x17.
// RULE20: Delays are counted by a 0.5 ms tick, started on enable edges.
package osc_pkg;

    localparam logic [7:0] OSC_ADDR_OUT1_DELAY = 8'h10;
    localparam logic [7:0] OSC_ADDR_OUT2_DELAY = 8'h11;
    localparam logic [7:0] OSC_ADDR_GENERAL_OUTPUT_CONTROL   = 8'h12;
    localparam logic [7:0] OSC_ADDR_MISC_CFG   = 8'h13;
    localparam logic [7:0] OSC_ADDR_CLK_CTRL   = 8'h14;

    localparam logic [7:0] OSC_RST_OUT1_DELAY = 8'h00;
    localparam logic [7:0] OSC_RST_OUT2_DELAY = 8'h00;
    localparam logic [7:0] OSC_RST_GENERAL_OUTPUT_CONTROL   = 8'h00;
    localparam logic [7:0] OSC_RST_MISC_CFG   = 8'h00;
    localparam logic [7:0] OSC_RST_CLK_CTRL   = 8'h00;

    // Writable masks; reserved bits read as zero
    localparam logic [7:0] OSC_MASK_GENERAL_OUTPUT_CONTROL  = 8'h77;
    localparam logic [7:0] OSC_MASK_MISC_CFG  = 8'h7F;
    localparam logic [7:0] OSC_MASK_CLK_CTRL  = 8'h5F;

    localparam int OSC_OFF_HI = 7;
    localparam int OSC_OFF_LO = 4;
    localparam int OSC_ON_HI  = 3;
    localparam int OSC_ON_LO  = 0;

    localparam int OSC_CTL_OUT2_OD   = 6;
    localparam int OSC_CTL_OUT2_GATE = 5;
    localparam int OSC_CTL_OUT2_LVL  = 4;
    localparam int OSC_CTL_OUT1_OD   = 2;
    localparam int OSC_CTL_OUT1_GATE = 1;
    localparam int OSC_CTL_OUT1_LVL  = 0;

    localparam int OSC_CFG_ON_RANGE  = 6;
    localparam int OSC_CFG_OFF_RANGE = 5;
    localparam int OSC_CFG_SYNC_FN   = 4;
    localparam int OSC_CFG_SYNC_PD   = 3;
    localparam int OSC_CFG_WAKE_PD   = 2;
    localparam int OSC_CFG_THERM     = 1;
    localparam int OSC_CFG_DITHER    = 0;

    localparam int OSC_PLL_EN        = 6;
    localparam int OSC_FREQ_HI       = 4;
    localparam int OSC_FREQ_LO       = 0;

    localparam int OSC_CLK_MHZ       = 125;
    localparam int OSC_STEP_US       = 500;
    localparam int OSC_TICK_CYCLES   = OSC_STEP_US * OSC_CLK_MHZ;

    typedef struct packed {
        logic [3:0] off_code;
        logic [3:0] on_code;
    } osc_delay_t;

    typedef struct packed {
        logic       o_o;
        logic       o_oe;
    } osc_pin_t;

endpackage : osc_pkg

/* verilog/osc_seq_chan.sv */
/*
 * One sequenced channel: follows the enable pin with separate rise and
 * fall delays counted in half-millisecond ticks.
 * Assumes a shared tick pulse and an enable level synchronous to the clock.
 */
`timescale 1ns/10ps
module osc_seq_chan (
    input  wire logic              clk_i,       // System clock
    input  wire logic              rst_i,       // Synchronous reset
    input  wire logic              tick_i,      // 0.5 ms pulse
    input  wire logic              en_i,        // Enable pin level
    input  wire osc_pkg::osc_delay_t dly_i,     // Delay codes
    input  wire logic              on_rng_i,    // Rise uses 1 ms steps
    input  wire logic              off_rng_i,   // Fall uses 1 ms steps
    output logic                   seq_o        // Delayed enable
);
    import osc_pkg::*;

    logic       en_q;
    logic [4:0] cnt_q;
    logic [4:0] cnt_d;
    logic       seq_q;
    logic       seq_d;
    logic       busy_q;
    logic       busy_d;

    wire        edge_w  = en_i ^ en_q;
    wire  [3:0] code_w  = en_i ? dly_i.on_code : dly_i.off_code;
    wire        rng_w   = en_i ? on_rng_i : off_rng_i;
    // Doubling the code gives 1 ms steps from the one 0.5 ms tick
    wire  [4:0] load_w  = rng_w ? {code_w, 1'b0} : {1'b0, code_w}; // RULE5 RULE6

    always_comb begin
        cnt_d  = cnt_q;
        seq_d  = seq_q;
        busy_d = busy_q;
        if (edge_w) begin
            // A new edge restarts timing toward the new level
            if (load_w == 5'h0_0) begin
                seq_d  = en_i;
                busy_d = 1'b0;
            end else begin
                cnt_d  = load_w; // RULE20
                busy_d = 1'b1;
            end
        end else if (busy_q && tick_i) begin
            if (cnt_q == 5'h0_1) begin
                seq_d  = en_q; // RULE1 RULE2 RULE3 RULE4
                busy_d = 1'b0;
            end
            cnt_d = cnt_q - 5'h0_1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            en_q   <= 1'b0;
            cnt_q  <= 5'h0_0;
            seq_q  <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            en_q   <= en_i;
            cnt_q  <= cnt_d;
            seq_q  <= seq_d;
            busy_q <= busy_d;
        end
    end

    assign seq_o = seq_q;

endmodule : osc_seq_chan

/* verilog/osc_regs.sv */
/*
 * Output sequencing and configuration register bank: registers, the
 * half-millisecond tick, two sequenced channels and pin drive logic.
 * Assumes a simple register port from the serial interface: one-cycle
 * write strobe, combinational read data, all inputs synchronous.
 */
`timescale 1ns/10ps
module osc_regs (
    input  wire logic        MCLK_I,           // 125 MHz clock
    input  wire logic        RESET_I,          // Synchronous reset, high
    input  wire logic [7:0]  REG_ADDR_I,       // Register address
    input  wire logic        REG_WR_I,         // Write strobe
    input  wire logic [7:0]  REG_WDATA_I,      // Write data
    output logic      [7:0]  REG_RDATA_O,      // Read data
    input  wire logic        WAKE_PIN_I,       // Enable pin level
    input  wire logic        EXT_CLK_SEEN_I,   // External clock detected
    output logic             OUT1_O,           // Output one data
    output logic             OUT1_OE_O,        // Output one enable
    output logic             OUT2_O,           // Output two data
    output logic             OUT2_OE_O,        // Output two enable
    output logic             SYNC_PIN_PD_O,    // Sync pin pull-down on
    output logic             WAKE_PIN_PD_O,    // Enable pin pull-down on
    output logic             THERM_HI_O,       // 137 C threshold chosen
    output logic             DITHER_ON_O,      // Spread spectrum on
    output logic             SYNC_IS_CLK_O,    // Sync pin is clock input
    output logic [4:0]       SYNC_FREQ_O,      // External clock code
    output logic             USE_EXT_CLK_O,    // Running from external clock
    output logic             CLK_EVENT_O       // One-cycle clock change event
);
    import osc_pkg::*;

    localparam logic [16:0] TICK_LAST = 17'(OSC_TICK_CYCLES - 1);

    logic [7:0]  dly1_q;
    logic [7:0]  dly2_q;
    logic [7:0]  ctl_q;
    logic [7:0]  cfg_q;
    logic [7:0]  pll_q;
    logic [16:0] tick_cnt_q;
    logic        use_ext_q;
    logic        ev_q;
    logic        seq1_w;
    logic        seq2_w;

    wire wr_d1 = REG_WR_I && (REG_ADDR_I == OSC_ADDR_OUT1_DELAY);
    wire wr_d2 = REG_WR_I && (REG_ADDR_I == OSC_ADDR_OUT2_DELAY);
    wire wr_ct = REG_WR_I && (REG_ADDR_I == OSC_ADDR_GENERAL_OUTPUT_CONTROL);
    wire wr_cf = REG_WR_I && (REG_ADDR_I == OSC_ADDR_MISC_CFG);
    wire wr_pl = REG_WR_I && (REG_ADDR_I == OSC_ADDR_CLK_CTRL);
    wire tick_w = (tick_cnt_q == TICK_LAST); // RULE20

    always_ff @(posedge MCLK_I) begin
        if (RESET_I) begin
            dly1_q <= OSC_RST_OUT1_DELAY;
            dly2_q <= OSC_RST_OUT2_DELAY;
            ctl_q  <= OSC_RST_GENERAL_OUTPUT_CONTROL;
            cfg_q  <= OSC_RST_MISC_CFG;
            pll_q  <= OSC_RST_CLK_CTRL;
        end else begin
            if (wr_d1) dly1_q <= REG_WDATA_I;
            if (wr_d2) dly2_q <= REG_WDATA_I;
            if (wr_ct) ctl_q  <= REG_WDATA_I & OSC_MASK_GENERAL_OUTPUT_CONTROL;
            if (wr_cf) cfg_q  <= REG_WDATA_I & OSC_MASK_MISC_CFG;
            // Reserved bit 5 is not stored, so a stray 1 has no effect
            if (wr_pl) pll_q  <= REG_WDATA_I & OSC_MASK_CLK_CTRL; // RULE18
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (RESET_I) begin
            tick_cnt_q <= 17'h0_0000;
        end else if (tick_w) begin
            tick_cnt_q <= 17'h0_0000;
        end else begin
            tick_cnt_q <= tick_cnt_q + 17'h0_0001;
        end
    end

    // Clock source selection and change event
    wire pll_en_w  = pll_q[OSC_PLL_EN];
    wire use_ext_d = pll_en_w && EXT_CLK_SEEN_I; // RULE16 RULE17

    always_ff @(posedge MCLK_I) begin
        if (RESET_I) begin
            use_ext_q <= 1'b0;
            ev_q      <= 1'b0;
        end else begin
            use_ext_q <= use_ext_d;
            ev_q      <= pll_en_w && (use_ext_d != use_ext_q); // RULE17
        end
    end

    osc_seq_chan u_chan1 (
        .clk_i     (MCLK_I),
        .rst_i     (RESET_I),
        .tick_i    (tick_w),
        .en_i      (WAKE_PIN_I),
        .dly_i     (osc_delay_t'(dly1_q)),
        .on_rng_i  (cfg_q[OSC_CFG_ON_RANGE]),
        .off_rng_i (cfg_q[OSC_CFG_OFF_RANGE]),
        .seq_o     (seq1_w)
    );

    osc_seq_chan u_chan2 (
        .clk_i     (MCLK_I),
        .rst_i     (RESET_I),
        .tick_i    (tick_w),
        .en_i      (WAKE_PIN_I),
        .dly_i     (osc_delay_t'(dly2_q)),
        .on_rng_i  (cfg_q[OSC_CFG_ON_RANGE]),
        .off_rng_i (cfg_q[OSC_CFG_OFF_RANGE]),
        .seq_o     (seq2_w)
    );

    // Gated outputs follow the sequenced enable, so the pin edges carry the delays
    wire lvl1_w = ctl_q[OSC_CTL_OUT1_LVL] &
                  (~ctl_q[OSC_CTL_OUT1_GATE] | seq1_w); // RULE10 RULE11
    wire lvl2_w = ctl_q[OSC_CTL_OUT2_LVL] &
                  (~ctl_q[OSC_CTL_OUT2_GATE] | seq2_w); // RULE8 RULE9
    wire out2_on_w = ~cfg_q[OSC_CFG_SYNC_FN]; // RULE12

    logic [1:0] pin1_q;
    logic [1:0] pin2_q;
    // Open drain only pulls low; push-pull drives, output two only while the sync pin is not a clock input
    wire osc_pin_t pin1_d = '{o_o: lvl1_w,
                             o_oe: ~ctl_q[OSC_CTL_OUT1_OD] | ~lvl1_w}; // RULE7
    wire osc_pin_t pin2_d = '{o_o: lvl2_w,
                             o_oe: out2_on_w & (~ctl_q[OSC_CTL_OUT2_OD] | ~lvl2_w)}; // RULE7

    always_ff @(posedge MCLK_I) begin
        if (RESET_I) begin
            pin1_q <= 2'h0;
            pin2_q <= 2'h0;
        end else begin
            pin1_q <= pin1_d;
            pin2_q <= pin2_d;
        end
    end

    assign OUT1_O        = pin1_q[1];
    assign OUT1_OE_O     = pin1_q[0];
    assign OUT2_O        = pin2_q[1];
    assign OUT2_OE_O     = pin2_q[0];
    assign SYNC_PIN_PD_O = cfg_q[OSC_CFG_SYNC_PD]; // RULE13
    assign WAKE_PIN_PD_O = cfg_q[OSC_CFG_WAKE_PD]; // RULE13
    assign THERM_HI_O    = cfg_q[OSC_CFG_THERM]; // RULE14
    assign DITHER_ON_O   = cfg_q[OSC_CFG_DITHER]; // RULE15
    assign SYNC_IS_CLK_O = cfg_q[OSC_CFG_SYNC_FN]; // RULE12
    assign SYNC_FREQ_O   = pll_q[OSC_FREQ_HI:OSC_FREQ_LO];
    assign USE_EXT_CLK_O = use_ext_q;
    assign CLK_EVENT_O   = ev_q;

    // Unmapped addresses read as zero
    assign REG_RDATA_O =
        (REG_ADDR_I == OSC_ADDR_OUT1_DELAY) ? dly1_q :
        (REG_ADDR_I == OSC_ADDR_OUT2_DELAY) ? dly2_q :
        (REG_ADDR_I == OSC_ADDR_GENERAL_OUTPUT_CONTROL)   ? ctl_q  :
        (REG_ADDR_I == OSC_ADDR_MISC_CFG)   ? cfg_q  :
        (REG_ADDR_I == OSC_ADDR_CLK_CTRL)   ? pll_q  : 8'h00;

endmodule : osc_regs

/* test/osc_regs_properties.sv */
/* Port checker for osc_regs with shadow copies of the control registers.
 * Assumes only the top ports are visible; bound by the statement below. */
`timescale 1ns/10ps
module osc_regs_props import osc_pkg::*; (
    input wire logic       MCLK_I,
    input wire logic       RESET_I,
    input wire logic [7:0] REG_ADDR_I,
    input wire logic       REG_WR_I,
    input wire logic [7:0] REG_WDATA_I,
    input wire logic       EXT_CLK_SEEN_I,
    input wire logic       OUT1_O,
    input wire logic       OUT1_OE_O,
    input wire logic       OUT2_OE_O,
    input wire logic       SYNC_PIN_PD_O,
    input wire logic       WAKE_PIN_PD_O,
    input wire logic       THERM_HI_O,
    input wire logic       DITHER_ON_O,
    input wire logic       SYNC_IS_CLK_O,
    input wire logic       USE_EXT_CLK_O,
    input wire logic       CLK_EVENT_O
);
    logic [7:0] ctl_q;
    logic [7:0] ctl_p;
    logic [7:0] cfg_q;
    logic       pll_q;
    wire        steady = (ctl_q == ctl_p);
    // Past copy resets to all ones so pins are not judged before they settle
    always_ff @(posedge MCLK_I) begin
        ctl_p <= RESET_I ? 8'hFF : ctl_q;
        if (RESET_I) begin
            ctl_q <= 8'h00;
            cfg_q <= 8'h00;
            pll_q <= 1'b0;
        end else if (REG_WR_I) begin
            if (REG_ADDR_I == OSC_ADDR_GENERAL_OUTPUT_CONTROL) ctl_q <= REG_WDATA_I & OSC_MASK_GENERAL_OUTPUT_CONTROL;
            if (REG_ADDR_I == OSC_ADDR_MISC_CFG) cfg_q <= REG_WDATA_I & OSC_MASK_MISC_CFG;
            if (REG_ADDR_I == OSC_ADDR_CLK_CTRL) pll_q <= REG_WDATA_I[OSC_PLL_EN];
        end
    end
    default clocking @(posedge MCLK_I); endclocking
    default disable iff (RESET_I);
    chk_clk_mode_release: assert property (
        SYNC_IS_CLK_O && $past(SYNC_IS_CLK_O) |-> !OUT2_OE_O)
        else $error("output two driven in clock mode");
    chk_open_drain_one: assert property (steady && ctl_q[2] |-> !(OUT1_O && OUT1_OE_O))
        else $error("open drain output drove high");
    chk_push_pull_one: assert property (steady && !ctl_q[2] |-> OUT1_OE_O)
        else $error("push-pull output not driven");
    chk_level_one: assert property (steady && ctl_q[2:1] == 2'h0 |-> OUT1_O == ctl_q[0])
        else $error("output one level wrong");
    chk_pulldown_bits: assert property ({SYNC_PIN_PD_O, WAKE_PIN_PD_O} == cfg_q[3:2])
        else $error("pull-down select wrong");
    chk_thermal_sel: assert property (THERM_HI_O == cfg_q[1])
        else $error("thermal select wrong");
    chk_dither_bit: assert property (DITHER_ON_O == cfg_q[0])
        else $error("spread spectrum wrong");
    chk_ext_clk_use: assert property (USE_EXT_CLK_O == $past(pll_q && EXT_CLK_SEEN_I))
        else $error("clock source wrong");
    chk_clk_event: assert property (
        pll_q && $changed(USE_EXT_CLK_O) |-> ##[0:1] CLK_EVENT_O)
        else $error("clock change event missing");
    // Past copy of the enable: a write may turn the PLL off on the very edge of the event
    chk_event_cause: assert property (
        CLK_EVENT_O |-> $changed(USE_EXT_CLK_O) && $past(pll_q))
        else $error("clock change event without a source change");
    cover property (steady && ctl_q[2] && OUT1_OE_O);
    cover property ($rose(USE_EXT_CLK_O));
    cover property (SYNC_IS_CLK_O && steady);
endmodule : osc_regs_props
bind osc_regs osc_regs_props u_props (.MCLK_I, .RESET_I, .REG_ADDR_I, .REG_WR_I, .REG_WDATA_I,
    .EXT_CLK_SEEN_I, .OUT1_O, .OUT1_OE_O, .OUT2_OE_O, .SYNC_PIN_PD_O, .WAKE_PIN_PD_O,
    .THERM_HI_O, .DITHER_ON_O, .SYNC_IS_CLK_O, .USE_EXT_CLK_O, .CLK_EVENT_O);

/* test/osc_host_model.sv */
/* Host model: register writes, enable pin and external clock presence.
 * Assumes the caller is in step with clk_i; drives just after rising edges. */
`timescale 1ns/10ps
module osc_host_model import osc_pkg::*; (
    input  wire logic       clk_i,   // Clock
    output logic      [7:0] addr_o,  // Address
    output logic            wr_o,    // Write strobe
    output logic      [7:0] wdata_o, // Write data
    output logic            wake_o,  // Enable pin
    output logic            ext_o    // External clock present
);
    initial {addr_o, wr_o, wdata_o, wake_o, ext_o} = '0;
    task automatic put(input logic [7:0] a, input logic [7:0] d, input logic w);
        logic [7:0] v;
        v = (a == OSC_ADDR_CLK_CTRL) ? (d & 8'hDF) : d;
        if (a == OSC_ADDR_CLK_CTRL && v[4:0] > 5'h17) v[4:0] = 5'h17;
        @(posedge clk_i);
        addr_o  <= a;
        wdata_o <= v;
        wr_o    <= w;
        @(posedge clk_i);
        wr_o    <= 1'b0;
        // Data lines do not keep a stale value once released
        wdata_o <= ~v;
    endtask : put
    task automatic pins(input logic w, input logic e);
        @(posedge clk_i);
        wake_o <= w;
        ext_o  <= e;
    endtask : pins
endmodule : osc_host_model

/* test/osc_regs_tb.sv */
/* Self-checking bench for osc_regs: queued expectations, one monitor.
 * Assumes the host model drives all register and pin inputs. */
`timescale 1ns/10ps
module osc_regs_tb import osc_pkg::*;;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr, wdata, rdata;
    logic wr, wake, ext, o1, oe1, o2, oe2, spd, wpd, thr, dit, sclk, use_x, evt;
    logic [4:0] frq;
    logic [11:0] exp_q[$];
    logic [7:0] ctl_tab[9] = '{8'h01, 8'h03, 8'h07, 8'h04, 8'h10, 8'h30, 8'h70, 8'h50, 8'h33};
    int miscompares = 0;
    int compares = 0;
    int cyc = 0;
    int seed = 76;
    int evts = 0;
    event probe;
    initial forever #4 clk = ~clk;
    osc_host_model u_host (.clk_i(clk), .addr_o(addr), .wr_o(wr), .wdata_o(wdata),
        .wake_o(wake), .ext_o(ext));
    osc_regs u_dut (.MCLK_I(clk), .RESET_I(rst), .REG_ADDR_I(addr), .REG_WR_I(wr),
        .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .WAKE_PIN_I(wake), .EXT_CLK_SEEN_I(ext),
        .OUT1_O(o1), .OUT1_OE_O(oe1), .OUT2_O(o2), .OUT2_OE_O(oe2), .SYNC_PIN_PD_O(spd),
        .WAKE_PIN_PD_O(wpd), .THERM_HI_O(thr), .DITHER_ON_O(dit), .SYNC_IS_CLK_O(sclk),
        .SYNC_FREQ_O(frq), .USE_EXT_CLK_O(use_x), .CLK_EVENT_O(evt));
    // The event pulse stands one cycle, so the falling edge always sees it
    always @(negedge clk) if (evt === 1'b1) evts++;
    task automatic check(input logic [7:0] seen, input logic [7:0] want_v);
        compares++;
        if (seen !== want_v) begin
            miscompares++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, want_v);
        end
    endtask : check
    function automatic logic [7:0] pick(input logic [3:0] k);
        case (k)
            4'h0: return rdata;
            4'h1: return {4'h0, oe2, oe2 & o2, oe1, oe1 & o1};
            4'h2: return {3'h0, spd, wpd, thr, dit, sclk};
            4'h3: return {3'h0, frq};
            4'h5: return 8'(evts);
            default: return {7'h00, use_x};
        endcase
    endfunction : pick
    function automatic logic [7:0] pins(input logic [7:0] c, input logic w);
        logic l1, l2;
        l1 = c[0] & (w | ~c[1]);
        l2 = c[4] & (w | ~c[5]);
        return {4'h0, ~(c[6] & l2), l2 & ~c[6], ~(c[2] & l1), l1 & ~c[2]};
    endfunction : pins
    always @(probe) begin
        logic [11:0] e;
        e = exp_q.pop_front();
        check(pick(e[11:8]), e[7:0]);
    end
    task automatic want(input logic [3:0] k, input logic [7:0] v);
        @(negedge clk);
        exp_q.push_back({k, v});
        -> probe;
        #1;
    endtask : want
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] m);
        u_host.put(a, d, 1'b1);
        u_host.put(a, 8'h00, 1'b0);
        want(4'h0, d & m);
    endtask : wr_rd
    task automatic complete_run;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : complete_run
    always @(posedge clk) begin
        cyc++;
        if (cyc == 90000) begin
            miscompares++;
            complete_run();
        end
    end
    initial begin
        logic [7:0] d;
        logic [7:0] c;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        for (int a = 16; a < 22; a++) begin
            u_host.put(8'(a), 8'h00, 1'b0);
            want(4'h0, 8'h00);
        end
        for (int i = 0; i < 6; i++) begin
            d = $random(seed);
            c = {1'b0, d[6], 1'b0, 5'(d[4:0] % 24)};
            wr_rd(OSC_ADDR_OUT1_DELAY, d, 8'hFF);
            wr_rd(OSC_ADDR_OUT2_DELAY, ~d, 8'hFF);
            wr_rd(OSC_ADDR_GENERAL_OUTPUT_CONTROL, d, OSC_MASK_GENERAL_OUTPUT_CONTROL);
            wr_rd(OSC_ADDR_MISC_CFG, d, OSC_MASK_MISC_CFG);
            want(4'h2, {3'h0, d[3:0], d[4]});
            wr_rd(OSC_ADDR_CLK_CTRL, c, 8'hFF);
            want(4'h3, {3'h0, c[4:0]});
            wr_rd(8'h15, d, 8'h00);
        end
        $display("test registers done");
        wr_rd(OSC_ADDR_OUT1_DELAY, 8'h00, 8'hFF);
        wr_rd(OSC_ADDR_OUT2_DELAY, 8'h00, 8'hFF);
        wr_rd(OSC_ADDR_MISC_CFG, 8'h00, 8'hFF);
        foreach (ctl_tab[j]) for (int w = 0; w < 2; w++) begin
            u_host.pins(w[0], 1'b0);
            u_host.put(OSC_ADDR_GENERAL_OUTPUT_CONTROL, ctl_tab[j], 1'b1);
            repeat (4) @(posedge clk);
            want(4'h1, pins(ctl_tab[j], w[0]));
        end
        u_host.put(OSC_ADDR_MISC_CFG, 8'h10, 1'b1);
        repeat (3) @(posedge clk);
        want(4'h1, pins(8'h33, 1'b1) & 8'hF3);
        $display("test pins done");
        u_host.put(OSC_ADDR_CLK_CTRL, 8'h47, 1'b1);
        u_host.pins(1'b0, 1'b1);
        repeat (3) @(posedge clk);
        want(4'h4, 8'h01);
        u_host.put(OSC_ADDR_CLK_CTRL, 8'h07, 1'b1);
        repeat (3) @(posedge clk);
        want(4'h4, 8'h00);
        want(4'h5, 8'h01);
        $display("test clock done");
        u_host.put(OSC_ADDR_MISC_CFG, 8'h00, 1'b1);
        u_host.put(OSC_ADDR_OUT1_DELAY, 8'h01, 1'b1);
        u_host.put(OSC_ADDR_OUT2_DELAY, 8'h01, 1'b1);
        u_host.put(OSC_ADDR_GENERAL_OUTPUT_CONTROL, 8'h33, 1'b1);
        repeat (4) @(posedge clk);
        u_host.pins(1'b1, 1'b0);
        repeat (8) @(posedge clk);
        // The tick runs free from reset, so the first one is still far off here
        want(4'h1, pins(8'h33, 1'b0));
        // One step of at most 62500 cycles plus pipeline slack
        for (int n = 0; n < 62520 && o1 !== 1'b1; n++) @(posedge clk);
        want(4'h1, pins(8'h33, 1'b1));
        u_host.pins(1'b0, 1'b0);
        repeat (5) @(posedge clk);
        want(4'h1, pins(8'h33, 1'b0));
        $display("test delay done");
        complete_run();
    end
endmodule : osc_regs_tb
